// ### rfes_pkg.sv
// constants, field layout and types of the regen front end sequencer
// assumes a 250 MHz system clock and a 32-bit apb register port
package rfes_pkg;

    localparam int CLK_HZ       = 250_000_000;
    localparam int LOCK_MS      = 100;
    localparam int FREQ_HIGH_HZ = 70;
    localparam int FREQ_LOW_HZ  = 40;
    // lock window rounds down; period thresholds in clock cycles
    localparam int LOCK_CYC     = CLK_HZ / 1000 * LOCK_MS;
    localparam int OVF_CYC      = CLK_HZ / FREQ_HIGH_HZ;
    localparam int UNF_CYC      = CLK_HZ / FREQ_LOW_HZ;
    localparam int STALE_CYC    = 2 * UNF_CYC;
    localparam int PW           = 25;

    // register byte addresses
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_VSP   = 8'h04;
    localparam logic [7:0] A_ACT   = 8'h08;
    localparam logic [7:0] A_REACT = 8'h0C;
    localparam logic [7:0] A_ILIM  = 8'h10;
    localparam logic [7:0] A_STAT  = 8'h14;
    localparam logic [7:0] A_PER   = 8'h18;
    localparam logic [7:0] A_ISTS  = 8'h1C;
    localparam logic [7:0] A_ICLR  = 8'h20;
    localparam logic [7:0] A_IEN   = 8'h24;

    // control bits
    localparam int C_RUN    = 0;
    localparam int C_BRAKE  = 1;
    localparam int C_CURR   = 2;
    localparam int C_HWSYNC = 3;
    localparam int C_CLOSE  = 4;
    localparam int CW       = 5;
    localparam logic [CW-1:0] CTRL_RST = 5'h10;

    localparam int VW = 10;
    localparam logic [VW-1:0] VSP_RST = 10'h2D0;
    localparam logic [VW-1:0] VSP_MAX = 10'h3E8;

    // currents are signed q12: 1.0 pu = 4096
    localparam logic signed [15:0] I_MAX   = 16'sh1800;
    localparam logic signed [15:0] ACT_RST = 16'sh019A;
    localparam logic signed [15:0] I_ZERO  = 16'sh0000;

    // interrupt bits
    localparam int I_LOCKED = 0;
    localparam int I_FAIL   = 1;
    localparam int I_PLOSS  = 2;
    localparam int I_FREQ   = 3;
    localparam int I_PRECH  = 4;
    localparam int IW       = 5;

    typedef logic [PW-1:0] rfes_per_t;

    typedef enum logic [2:0] {
        ST_INACTIVE, ST_LOCKING, ST_LOCKED,
        ST_OVERFREQ, ST_UNDERFREQ, ST_FAILED
    } rfes_status_e;

    typedef enum logic [1:0] {
        SQ_IDLE, SQ_LOCK, SQ_RUN, SQ_FAIL
    } rfes_seq_e;

    function automatic logic signed [15:0] rfes_sat(
        input logic signed [15:0] x,
        input logic signed [15:0] lim);
        if (x > lim)
            rfes_sat = lim;
        else if (x < -lim)
            rfes_sat = -lim;
        else
            rfes_sat = x;
    endfunction

endpackage

// ### rfes_freq_if.sv
// mains period measurement shared between meter and sequencer
// assumes both ends run on the system clock
`timescale 1ns/10ps
`default_nettype none
interface rfes_freq_if;
    import rfes_pkg::*;
    rfes_per_t period;
    logic      valid;
    logic      over;
    logic      under;
    modport meter (output period, output valid, output over,
                   output under);
    modport user  (input period, input valid, input over,
                   input under);
endinterface
`default_nettype wire

// ### rfes_sync2.sv
// two flip-flop synchroniser for a group of pin inputs
// assumes pins are asynchronous to clk_i
`timescale 1ns/10ps
`default_nettype none
module rfes_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         ce_i,
    // pins in, synced out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else if (ce_i) begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule // rfes_sync2
`default_nettype wire

// ### rfes_freq_meter.sv
// measures the mains period between zero-crossing strobes
// assumes xing_i is a one-cycle strobe on clk_i
`timescale 1ns/10ps
`default_nettype none
module rfes_freq_meter #(
    parameter int OVF   = rfes_pkg::OVF_CYC,
    parameter int UNF   = rfes_pkg::UNF_CYC,
    parameter int STALE = rfes_pkg::STALE_CYC
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic ce_i,
    // crossing strobe and result
    input  wire logic xing_i,
    rfes_freq_if.meter fq
);
    import rfes_pkg::*;

    rfes_per_t cnt_q;
    logic      seen_q;
    rfes_per_t per_q;
    logic      valid_q;

    // a single crossing gives no period; two are needed
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_q   <= '0;
            seen_q  <= 1'b0;
            per_q   <= '0;
            valid_q <= 1'b0;
        end else if (ce_i) begin
            if (xing_i) begin
                cnt_q   <= PW'(1);
                seen_q  <= 1'b1;
                per_q   <= cnt_q;
                valid_q <= seen_q;
            end else if (cnt_q >= PW'(STALE)) begin
                seen_q  <= 1'b0;
                valid_q <= 1'b0;
            end else begin
                cnt_q   <= cnt_q + PW'(1);
            end
        end
    end

    assign fq.period = per_q;
    assign fq.valid  = valid_q;
    assign fq.over   = valid_q && (per_q < PW'(OVF));
    assign fq.under  = valid_q && (per_q > PW'(UNF));
endmodule // rfes_freq_meter
`default_nettype wire

// ### rfes_sequencer.sv
// regen front end sequencer: apb registers, mains lock, monitoring
// assumes vdc_i and soft_xing_i come from logic on clk_i
//
// What this block does
// - Brake mode returns energy only while link volts exceed setpoint.
// - Braking mode never draws energy from the mains.
// - Current mode: active setpoint default 0.1, reactive within 1.5.
// - Current mode clamps current to a limit 0..1.5, default 1.5.
// - Current select flag picks current or voltage control, default off.
// - Sync source flag picks line-sync pin or software estimate.
// - First 100 ms after run: locking indication and status.
// - Locked indication only after a successful lock.
// - Phase-loss indication when an input phase seems missing while the run bit is set.
// - Contactor-close output drives precharge contactor, default true.
// - Drive enable only when locked and healthy, default false.
// - Status codes 0..5, reset value 4.
// - Over-frequency status above 70 Hz.
// - Under-frequency status below 40 Hz.
// - Lock-failed status when the mains cannot be locked.
`timescale 1ns/10ps
`default_nettype none
module rfes_sequencer #(
    parameter int LOCK_CYCLES  = rfes_pkg::LOCK_CYC,
    parameter int OVF_CYCLES   = rfes_pkg::OVF_CYC,
    parameter int UNF_CYCLES   = rfes_pkg::UNF_CYC,
    parameter int STALE_CYCLES = rfes_pkg::STALE_CYC
) (
    // clock, reset, enable
    input  wire logic                clk_i,
    input  wire logic                sys_rst_i,
    input  wire logic                ce_i,
    // apb slave
    input  wire logic [7:0]          paddr_i,
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [31:0]         pwdata_i,
    output logic      [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    // pins from the plant
    input  wire logic                precharge_closed_i,
    input  wire logic                line_sync_i,
    input  wire logic [2:0]          phase_present_i,
    // same-clock measurements
    input  wire logic                soft_xing_i,
    input  wire logic [rfes_pkg::VW-1:0] vdc_i,
    // sequencing outputs
    output logic                     contactor_close_o,
    output logic                     drive_enable_o,
    output logic                     mains_locking_o,
    output logic                     mains_locked_o,
    output logic                     phase_loss_o,
    output rfes_pkg::rfes_status_e   status_o,
    // control references
    output logic                     current_mode_o,
    output logic signed [15:0]       active_ref_o,
    output logic signed [15:0]       reactive_ref_o,
    output logic [rfes_pkg::VW-1:0]  vdc_ref_o,
    // interrupt
    output logic                     irq_o
);
    import rfes_pkg::*;

    localparam int TW = PW;

    // registers
    logic [CW-1:0]      ctrl_q;
    logic [VW-1:0]      vsp_q;
    logic signed [15:0] act_q;
    logic signed [15:0] react_q;
    logic signed [15:0] ilim_q;
    logic [IW-1:0]      ists_q;
    logic [IW-1:0]      ien_q;
    logic [IW-1:0]      ev_d;

    // sequencer
    rfes_seq_e          seq_q;
    rfes_seq_e          seq_d;
    rfes_status_e       status_d;
    logic [TW-1:0]      tmr_q;
    logic               run_q;
    logic               healthy;

    // synchronised pins
    logic [4:0]         pins_s;
    logic               prech_s;
    logic               lsync_s;
    logic [2:0]         phase_s;
    logic               lsync_q;
    logic               xing;

    // apb decode
    logic               setup;
    logic               wr;
    logic               mapped;
    logic [31:0]        rd_d;
    logic signed [15:0] wsig;

    rfes_freq_if fq ();

    rfes_sync2 #(
        .W (5)
    ) u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .d_i       ({precharge_closed_i, line_sync_i, phase_present_i}),
        .q_o       (pins_s)
    );

    assign prech_s = pins_s[4];
    assign lsync_s = pins_s[3];
    assign phase_s = pins_s[2:0];

    // crossing source: line-sync pin edge or software estimate
    assign xing = ctrl_q[C_HWSYNC] ? (lsync_s & ~lsync_q)
                                   : soft_xing_i;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i)
            lsync_q <= 1'b0;
        else if (ce_i)
            lsync_q <= lsync_s;
    end

    rfes_freq_meter #(
        .OVF   (OVF_CYCLES),
        .UNF   (UNF_CYCLES),
        .STALE (STALE_CYCLES)
    ) u_meter (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .xing_i    (xing),
        .fq        (fq.meter)
    );

    // apb: zero-wait, data registered in the setup cycle
    assign setup  = psel_i & ~penable_i;
    assign wr     = psel_i & penable_i & pwrite_i & pready_o;
    assign wsig   = pwdata_i[15:0];

    always_comb begin
        mapped = 1'b1;
        rd_d   = 32'h0000_0000;
        case (paddr_i)
            A_CTRL:  rd_d[CW-1:0] = ctrl_q;
            A_VSP:   rd_d[VW-1:0] = vsp_q;
            A_ACT:   rd_d[15:0]   = act_q;
            A_REACT: rd_d[15:0]   = react_q;
            A_ILIM:  rd_d[15:0]   = ilim_q;
            A_STAT:  rd_d[8:0]    = {run_q, prech_s, drive_enable_o,
                                     phase_loss_o, mains_locked_o,
                                     mains_locking_o, status_o};
            A_PER:   rd_d[PW-1:0] = fq.period;
            A_ISTS:  rd_d[IW-1:0] = ists_q;
            A_ICLR:  rd_d         = 32'h0000_0000;
            A_IEN:   rd_d[IW-1:0] = ien_q;
            default: mapped       = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else if (ce_i) begin
            pready_o  <= setup;
            pslverr_o <= setup & ~mapped;
            if (setup & ~pwrite_i)
                prdata_o <= rd_d;
        end
    end

    // writable registers; setpoints saturate at their ranges
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl_q  <= CTRL_RST;
            vsp_q   <= VSP_RST;
            act_q   <= ACT_RST;
            react_q <= I_ZERO;
            ilim_q  <= I_MAX;
            ien_q   <= '0;
        end else if (ce_i && wr) begin
            case (paddr_i)
                A_CTRL:  ctrl_q <= pwdata_i[CW-1:0];
                A_VSP:   vsp_q  <= (pwdata_i > 32'(VSP_MAX)) ?
                                   VSP_MAX : pwdata_i[VW-1:0];
                A_ACT:   act_q  <= rfes_sat(wsig, I_MAX);
                A_REACT: react_q <= rfes_sat(wsig, I_MAX);
                A_ILIM:  ilim_q <= wsig[15] ? I_ZERO
                                   : rfes_sat(wsig, I_MAX);
                A_IEN:   ien_q  <= pwdata_i[IW-1:0];
                default: ;
            endcase
        end
    end

    // sequencer: run edge starts the lock window
    assign healthy = prech_s & (&phase_s);

    always_comb begin
        seq_d    = seq_q;
        status_d = status_o;
        if (!ctrl_q[C_RUN]) begin
            seq_d = SQ_IDLE;
        end else begin
            case (seq_q)
                SQ_IDLE: seq_d = run_q ? SQ_IDLE : SQ_LOCK;
                SQ_LOCK: begin
                    if (tmr_q >= TW'(LOCK_CYCLES - 1))
                        seq_d = (fq.valid && !fq.over && !fq.under)
                              ? SQ_RUN : SQ_FAIL;
                end
                SQ_RUN:  if (!fq.valid) seq_d = SQ_FAIL;
                SQ_FAIL: seq_d = SQ_FAIL;
                default: seq_d = SQ_IDLE;
            endcase
        end
        // fault codes win over the locked code
        case (seq_d)
            SQ_IDLE: if (seq_q != SQ_IDLE || run_q)
                         status_d = ST_INACTIVE;
            SQ_LOCK: status_d = ST_LOCKING;
            SQ_RUN: begin
                if (fq.over)
                    status_d = ST_OVERFREQ;
                else if (fq.under)
                    status_d = ST_UNDERFREQ;
                else
                    status_d = ST_LOCKED;
            end
            SQ_FAIL: status_d = ST_FAILED;
            default: status_d = ST_INACTIVE;
        endcase
    end

    // status holds its reset code until the first run command
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            seq_q    <= SQ_IDLE;
            status_o <= ST_UNDERFREQ;
            run_q    <= 1'b0;
            tmr_q    <= '0;
        end else if (ce_i) begin
            seq_q    <= seq_d;
            status_o <= status_d;
            run_q    <= ctrl_q[C_RUN];
            tmr_q    <= (seq_d == SQ_LOCK && seq_q == SQ_LOCK)
                      ? tmr_q + TW'(1) : '0;
        end
    end

    // indications and enables
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mains_locking_o   <= 1'b0;
            mains_locked_o    <= 1'b0;
            phase_loss_o      <= 1'b0;
            drive_enable_o    <= 1'b0;
            contactor_close_o <= 1'b1;
        end else if (ce_i) begin
            mains_locking_o   <= (seq_d == SQ_LOCK);
            mains_locked_o    <= (seq_d == SQ_RUN);
            phase_loss_o      <= ctrl_q[C_RUN] & ~(&phase_s);
            drive_enable_o    <= (status_d == ST_LOCKED)
                               & healthy;
            contactor_close_o <= ctrl_q[C_CLOSE];
        end
    end

    // references; positive active current draws from the mains
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            current_mode_o <= 1'b0;
            active_ref_o   <= I_ZERO;
            reactive_ref_o <= I_ZERO;
            vdc_ref_o      <= VSP_RST;
        end else if (ce_i) begin
            current_mode_o <= ctrl_q[C_CURR];
            vdc_ref_o      <= vsp_q;
            if (ctrl_q[C_BRAKE]) begin
                // brake unit: only sink, and only above setpoint
                active_ref_o   <= (vdc_i > vsp_q)
                                ? -ilim_q : I_ZERO;
                reactive_ref_o <= I_ZERO;
            end else if (ctrl_q[C_CURR]) begin
                active_ref_o   <= rfes_sat(act_q, ilim_q);
                reactive_ref_o <= rfes_sat(react_q, ilim_q);
            end else begin
                // voltage loop supplies the active demand downstream
                active_ref_o   <= I_ZERO;
                reactive_ref_o <= I_ZERO;
            end
        end
    end

    // interrupt events; a set in the clear cycle wins
    always_comb begin
        ev_d            = '0;
        ev_d[I_LOCKED]  = (seq_d == SQ_RUN) && (seq_q != SQ_RUN);
        ev_d[I_FAIL]    = (seq_d == SQ_FAIL) && (seq_q != SQ_FAIL);
        ev_d[I_PLOSS]   = ctrl_q[C_RUN] & ~(&phase_s) & ~phase_loss_o;
        ev_d[I_FREQ]    = (status_d == ST_OVERFREQ
                        || status_d == ST_UNDERFREQ)
                        && status_d != status_o;
        ev_d[I_PRECH]   = ctrl_q[C_RUN] & ~prech_s;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ists_q <= '0;
            irq_o  <= 1'b0;
        end else if (ce_i) begin
            if (wr && paddr_i == A_ICLR)
                ists_q <= (ists_q & ~pwdata_i[IW-1:0]) | ev_d;
            else
                ists_q <= ists_q | ev_d;
            irq_o  <= |(ists_q & ien_q);
        end
    end
    // checks
    a_enable_needs_lock: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        drive_enable_o |-> status_o == ST_LOCKED && mains_locked_o)
        else $error("drive enable without clean lock");
    a_fault_drops_enable: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        (status_o == ST_OVERFREQ || status_o == ST_UNDERFREQ
         || status_o == ST_FAILED) |-> !drive_enable_o)
        else $error("drive enabled during fault");
    a_brake_never_draws: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        ($past(ce_i) && $past(ctrl_q[C_BRAKE])) |-> active_ref_o <= 0)
        else $error("brake mode draws from mains");
    a_brake_below_idle: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        ($past(ce_i) && $past(ctrl_q[C_BRAKE]) && $past(vdc_i <= vsp_q))
        |-> active_ref_o == 0)
        else $error("regen below setpoint");
    a_locking_holds: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        (seq_q == SQ_LOCK && ctrl_q[C_RUN]
         && tmr_q < TW'(LOCK_CYCLES - 1))
        |=> seq_q == SQ_LOCK && status_o == ST_LOCKING
            && mains_locking_o)
        else $error("lock window ended early");
    a_failed_code: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        seq_q == SQ_FAIL |-> status_o == ST_FAILED && !mains_locked_o)
        else $error("lock failure not reported");
    a_reactive_range: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        react_q <= I_MAX && react_q >= -I_MAX && ilim_q <= I_MAX
        && (reactive_ref_o <= ilim_q || $changed(ilim_q)))
        else $error("reactive setpoint out of range");
    a_phase_loss_flag: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        ($past(ce_i) && $past(ctrl_q[C_RUN]) && $past(phase_s != 3'h7))
        |-> phase_loss_o)
        else $error("missing phase not flagged");
    a_irq_follows_status: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        $past(ce_i) |-> irq_o == |($past(ists_q) & $past(ien_q)))
        else $error("interrupt level wrong");
endmodule // rfes_sequencer
`default_nettype wire

// ### rfes_mains_model.sv
// mains supply and precharge contactor as seen from the sequencer pins
// assumes one system clock; a zero period stops all crossings
`timescale 1ns/10ps
`default_nettype none
module rfes_mains_model (
    // clock
    input  wire logic        clk_i,
    // settings from the bench, command from the sequencer
    input  wire logic [15:0] per_i,
    input  wire logic        use_hw_i,
    input  wire logic        close_i,
    // plant pins
    output logic             soft_xing_o,
    output logic             line_sync_o,
    output logic             precharge_o
);
    logic [15:0] cnt_q;
    logic [3:0]  shut_q;

    initial begin
        cnt_q = 16'h0000;
        shut_q = 4'h0;
        soft_xing_o = 1'b0;
        line_sync_o = 1'b0;
        precharge_o = 1'b0;
    end

    // only the selected source toggles, so a lock proves the path
    always @(posedge clk_i) begin
        cnt_q <= (per_i == 0 || cnt_q >= per_i - 1) ? 16'h0000 : cnt_q + 1;
        soft_xing_o <= per_i != 0 && !use_hw_i && cnt_q == 0;
        line_sync_o <= per_i != 0 && use_hw_i && cnt_q < per_i / 2;
    end

    // feedback only once the contactor has been closed a while
    always @(posedge clk_i) begin
        shut_q <= {shut_q[2:0], close_i};
        precharge_o <= &shut_q;
    end
endmodule // rfes_mains_model
`default_nettype wire

// ### rfes_sequencer_tb.sv
// self-checking bench: apb tasks, mains model, status sequences
// assumes the package, interface and sequencer compile first
`timescale 1ns/10ps
`default_nettype none
module rfes_sequencer_tb;
    import rfes_pkg::*;
    localparam int LK = 200;
    logic clk_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0;
    logic pwrite_i = 0, use_hw = 0, ce = 1, err, pready_o, pslverr_o, irq_o;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd;
    logic precharge_closed_i, line_sync_i, soft_xing_i;
    logic [2:0] phase_present_i = 3'b111;
    logic [VW-1:0] vdc_i = 10'h000, vdc_ref_o;
    logic [15:0] per = 16'h0000;
    logic contactor_close_o, drive_enable_o, mains_locking_o;
    logic mains_locked_o, phase_loss_o, current_mode_o;
    logic signed [15:0] active_ref_o, reactive_ref_o;
    rfes_status_e status_o;
    int num_errors = 0, n_tests = 0;

    always #2 clk_i = ~clk_i;

    rfes_sequencer #(.LOCK_CYCLES(LK), .OVF_CYCLES(30), .UNF_CYCLES(60),
        .STALE_CYCLES(130)) dut (.clk_i, .sys_rst_i, .ce_i(ce),
        .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .precharge_closed_i, .line_sync_i,
        .phase_present_i, .soft_xing_i, .vdc_i, .contactor_close_o,
        .drive_enable_o, .mains_locking_o, .mains_locked_o, .phase_loss_o,
        .status_o, .current_mode_o, .active_ref_o, .reactive_ref_o,
        .vdc_ref_o, .irq_o);

    rfes_mains_model mains (.clk_i, .per_i(per), .use_hw_i(use_hw),
        .close_i(contactor_close_o), .soft_xing_o(soft_xing_i),
        .line_sync_o(line_sync_i), .precharge_o(precharge_closed_i));

    task automatic report_and_stop;
        if (num_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask

    // request holds until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1;
        penable_i <= 0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask

    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
        apb(0, a, 0);
        chk(nm, rd, e);
    endtask

    task automatic wst(input rfes_status_e s, input int n);
        for (int i = 0; i < n && status_o !== s; i++)
            @(negedge clk_i);
        chk("status", {29'h0, status_o}, {29'h0, s});
    endtask

    task automatic run(input logic [31:0] c);
        apb(1, A_CTRL, 32'h10);
        apb(1, A_CTRL, c);
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 0;
        @(negedge clk_i);
        chk("status rst", {29'h0, status_o}, 32'h4);
        chk("close rst", contactor_close_o, 1);
        chk("enable rst", drive_enable_o, 0);
        chk("vref rst", vdc_ref_o, 720);
        rdc("ctrl", A_CTRL, 32'h10);
        rdc("ilim", A_ILIM, 6144);
        rdc("act", A_ACT, 410);
        apb(1, A_VSP, 1200);
        rdc("vsp sat", A_VSP, 1000);
        chk("vref", vdc_ref_o, 1000);
        apb(1, A_VSP, 720);
        apb(0, 8'h30, 0);
        chk("unmapped", err, 1);
        apb(1, A_ACT, 8000);
        rdc("act sat", A_ACT, 6144);
        apb(1, A_ILIM, 4096);
        apb(1, A_REACT, 32'hFFFF_FF9C);
        apb(1, A_CTRL, 32'h14);
        repeat (3) @(negedge clk_i);
        chk("mode", current_mode_o, 1);
        chk("act clamp", active_ref_o, 4096);
        chk("react", reactive_ref_o, 32'hFFFF_FF9C);
        apb(1, A_CTRL, 32'h10);
        repeat (3) @(negedge clk_i);
        chk("volt mode", {current_mode_o, active_ref_o}, 0);
        apb(1, A_CTRL, 32'h00);
        repeat (3) @(negedge clk_i);
        chk("open", contactor_close_o, 0);
        apb(1, A_CTRL, 32'h16);
        vdc_i <= 10'h320;
        repeat (3) @(negedge clk_i);
        chk("brake", active_ref_o, 32'hFFFF_F000);
        @(posedge clk_i);
        vdc_i <= 10'h2BC;
        ce <= 0;
        repeat (3) @(negedge clk_i);
        chk("freeze", active_ref_o, 32'hFFFF_F000);
        @(posedge clk_i);
        ce <= 1;
        repeat (3) @(negedge clk_i);
        chk("no draw", active_ref_o, 0);
        apb(1, A_IEN, 1);
        per <= 16'd45;
        run(32'h11);
        repeat (5) @(negedge clk_i);
        chk("locking", {mains_locking_o, mains_locked_o}, 2);
        chk("st lock", {29'h0, status_o}, 1);
        repeat (LK - 20) @(negedge clk_i);
        chk("locking end", mains_locking_o, 1);
        wst(ST_LOCKED, 60);
        repeat (3) @(negedge clk_i);
        chk("enable", {drive_enable_o, irq_o}, 3);
        rdc("ists", A_ISTS, 1);
        rdc("per", A_PER, 45);
        rdc("stat", A_STAT, 32'h0000_01D2);
        apb(1, A_ICLR, 1);
        repeat (2) @(negedge clk_i);
        chk("irq clr", irq_o, 0);
        @(posedge clk_i);
        phase_present_i <= 3'b110;
        repeat (6) @(negedge clk_i);
        chk("ploss", {phase_loss_o, drive_enable_o}, 2);
        @(posedge clk_i);
        phase_present_i <= 3'b111;
        per <= 16'd20;
        wst(ST_OVERFREQ, 200);
        chk("en fault", drive_enable_o, 0);
        apb(1, A_CTRL, 32'h10);
        wst(ST_INACTIVE, 4);
        per <= 16'd45;
        run(32'h11);
        wst(ST_LOCKED, LK + 60);
        per <= 16'd90;
        wst(ST_UNDERFREQ, 400);
        per <= 16'd0;
        run(32'h11);
        wst(ST_FAILED, LK + 60);
        chk("no lock", mains_locked_o, 0);
        use_hw <= 1;
        per <= 16'd45;
        run(32'h19);
        wst(ST_LOCKED, LK + 60);
        report_and_stop();
    end

    // whole run needs about 1100 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        report_and_stop();
    end
endmodule // rfes_sequencer_tb
`default_nettype wire
